// >>> hw/rat_opcode_match.sv
// Purpose: compares one instruction word against a fixed opcode
// Assumes: word and valid come from logic on the core clock
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module rat_opcode_match
    import rat_pkg::*;
#(
    parameter logic [RAT_WORD_W-1:0] CODE = 10'h000
)
(
    // instruction in
    input  wire logic [RAT_WORD_W-1:0] instr_word,
    input  wire logic                  instr_valid,
    // match out
    output logic                       hit
);

    assign hit = instr_valid && (instr_word == CODE);

endmodule : rat_opcode_match
`default_nettype wire

// >>> hw/rat_transfer_decoder.sv
// Purpose: decode and execute four single-word accumulator-load transfers
// Assumes: one instruction presented per machine cycle with instr_valid
// Notes:   results appear as one-cycle load strobes one edge later
//
// Summary of operation
// - prescaler high nibble to B, low to accumulator
// - port select to acc bits 2..0, bit 3 zero
// - interrupt control one copied to accumulator
// - wakeup control zero copied to accumulator
`timescale 1ns/1ps
`default_nettype none
module rat_transfer_decoder
    import rat_pkg::*;
(
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  reset_n,
    // instruction stream
    input  wire logic [RAT_WORD_W-1:0] instr_word,
    input  wire logic                  instr_valid,
    // source registers
    input  wire logic [RAT_PS_W-1:0]   prescaler_count,
    input  wire logic [RAT_SEL_W-1:0]  port_select_register,
    input  wire logic [RAT_NIB_W-1:0]  interrupt_control_one,
    input  wire logic [RAT_NIB_W-1:0]  wakeup_control_zero,
    // accumulator write port
    output logic [RAT_NIB_W-1:0]       acc_data_r,
    output logic                       acc_load_r,
    // register b write port
    output logic [RAT_NIB_W-1:0]       b_data_r,
    output logic                       b_load_r,
    // flag and sequencing side effects
    output logic                       carry_write_r,
    output logic                       skip_next_r,
    // status
    output logic                       executed_r,
    output logic                       not_decoded_r,
    output var rat_instr_type          last_instr_r
);

    logic          hit_prescaler;
    logic          hit_port_select;
    logic          hit_int_ctrl1;
    logic          hit_wake_ctrl0;
    rat_instr_type instr_kind;
    logic [RAT_NIB_W-1:0] acc_nxt;
    logic [RAT_NIB_W-1:0] b_nxt;
    logic          acc_load_nxt;
    logic          b_load_nxt;

    // opcode matchers, one per supported instruction
    rat_opcode_match #(
        .CODE        (RAT_OP_PRESCALER)
    ) u_match_prescaler (
        .instr_word  (instr_word),
        .instr_valid (instr_valid),
        .hit         (hit_prescaler)
    );

    rat_opcode_match #(
        .CODE        (RAT_OP_PORT_SELECT)
    ) u_match_port_select (
        .instr_word  (instr_word),
        .instr_valid (instr_valid),
        .hit         (hit_port_select)
    );

    rat_opcode_match #(
        .CODE        (RAT_OP_INT_CTRL1)
    ) u_match_int_ctrl1 (
        .instr_word  (instr_word),
        .instr_valid (instr_valid),
        .hit         (hit_int_ctrl1)
    );

    rat_opcode_match #(
        .CODE        (RAT_OP_WAKE_CTRL0)
    ) u_match_wake_ctrl0 (
        .instr_word  (instr_word),
        .instr_valid (instr_valid),
        .hit         (hit_wake_ctrl0)
    );

    // codes are distinct, so at most one matcher fires
    always_comb
    begin
        if (hit_prescaler)
        begin
            instr_kind = RAT_PRESCALER;
        end
        else if (hit_port_select)
        begin
            instr_kind = RAT_PORT_SELECT;
        end
        else if (hit_int_ctrl1)
        begin
            instr_kind = RAT_INT_CTRL1;
        end
        else if (hit_wake_ctrl0)
        begin
            instr_kind = RAT_WAKE_CTRL0;
        end
        else
        begin
            instr_kind = RAT_NONE;
        end
    end

    // source selection; sources are only read, never written back
    always_comb
    begin
        acc_nxt      = RAT_NIB_RST;
        b_nxt        = RAT_NIB_RST;
        acc_load_nxt = 1'b0;
        b_load_nxt   = 1'b0;
        case (instr_kind)
            RAT_PRESCALER:
            begin
                b_nxt        = prescaler_count[RAT_PS_W-1:RAT_PS_HI_LSB];
                acc_nxt      = prescaler_count[RAT_PS_HI_LSB-1:0];
                b_load_nxt   = 1'b1;
                acc_load_nxt = 1'b1;
            end
            RAT_PORT_SELECT:
            begin
                acc_nxt      = {RAT_ACC_TOP_FILL, port_select_register};
                acc_load_nxt = 1'b1;
            end
            RAT_INT_CTRL1:
            begin
                acc_nxt      = interrupt_control_one;
                acc_load_nxt = 1'b1;
            end
            RAT_WAKE_CTRL0:
            begin
                acc_nxt      = wakeup_control_zero;
                acc_load_nxt = 1'b1;
            end
            RAT_NONE:
            begin
                acc_nxt      = RAT_NIB_RST;
            end
            default:
            begin
                acc_nxt      = RAT_NIB_RST;
            end
        endcase
    end

    // accumulator write port, one edge after decode
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            acc_data_r <= RAT_NIB_RST;
            acc_load_r <= RAT_FLAG_RST;
        end
        else
        begin
            acc_load_r <= acc_load_nxt;
            if (acc_load_nxt)
            begin
                acc_data_r <= acc_nxt;
            end
        end
    end

    // register b write port
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            b_data_r <= RAT_NIB_RST;
            b_load_r <= RAT_FLAG_RST;
        end
        else
        begin
            b_load_r <= b_load_nxt;
            if (b_load_nxt)
            begin
                b_data_r <= b_nxt;
            end
        end
    end

    // these transfers never write carry nor request a skip
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            carry_write_r <= RAT_FLAG_RST;
            skip_next_r   <= RAT_FLAG_RST;
        end
        else
        begin
            carry_write_r <= RAT_FLAG_RST;
            skip_next_r   <= RAT_FLAG_RST;
        end
    end

    // status: completion pulse, foreign instruction pulse, last kind
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            executed_r    <= RAT_FLAG_RST;
            not_decoded_r <= RAT_FLAG_RST;
            last_instr_r  <= RAT_NONE;
        end
        else
        begin
            executed_r    <= (instr_kind != RAT_NONE);
            not_decoded_r <= instr_valid && (instr_kind == RAT_NONE);
            if (instr_kind != RAT_NONE)
            begin
                last_instr_r <= instr_kind;
            end
        end
    end

endmodule : rat_transfer_decoder
`default_nettype wire

// >>> pkg/rat_pkg.sv
// Purpose: shared constants for the accumulator-load transfer decoder
// Assumes: 10-bit instruction words, 4-bit data path
// Notes:   opcodes are the printed instruction codes
package rat_pkg;

    // widths
    localparam int RAT_WORD_W   = 10;
    localparam int RAT_NIB_W    = 4;
    localparam int RAT_PS_W     = 8;
    localparam int RAT_SEL_W    = 3;

    // instruction codes
    localparam logic [9:0] RAT_OP_PRESCALER   = 10'h275;
    localparam logic [9:0] RAT_OP_PORT_SELECT = 10'h051;
    localparam logic [9:0] RAT_OP_INT_CTRL1   = 10'h253;
    localparam logic [9:0] RAT_OP_WAKE_CTRL0  = 10'h256;

    // field positions
    localparam int RAT_PS_HI_LSB  = 4;
    localparam int RAT_ACC_TOP    = 3;

    // reset values and the port-select fill bit
    localparam logic [3:0] RAT_NIB_RST   = 4'h0;
    localparam logic       RAT_FLAG_RST  = 1'h0;
    localparam logic       RAT_ACC_TOP_FILL = 1'h0;

    // decoded instruction kinds
    typedef enum logic [2:0] {
        RAT_NONE,
        RAT_PRESCALER,
        RAT_PORT_SELECT,
        RAT_INT_CTRL1,
        RAT_WAKE_CTRL0
    } rat_instr_type;

endpackage : rat_pkg

// >>> test/rat_asserts.sv
// Purpose: port-level checks of the accumulator-load decoder
// Assumes: one instruction a cycle, results one edge later
// Notes:   bound to every decoder instance
`timescale 1ns/1ps
`default_nettype none
module rat_asserts
    import rat_pkg::*;
(
    // clock and reset
    input wire logic          core_clk,
    input wire logic          reset_n,
    // instruction and sources
    input wire logic [9:0]    instr_word,
    input wire logic          instr_valid,
    input wire logic [7:0]    prescaler_count,
    input wire logic [2:0]    port_select_register,
    input wire logic [3:0]    interrupt_control_one,
    input wire logic [3:0]    wakeup_control_zero,
    // results
    input wire logic [3:0]    acc_data_r,
    input wire logic          acc_load_r,
    input wire logic [3:0]    b_data_r,
    input wire logic          b_load_r,
    input wire logic          carry_write_r,
    input wire logic          skip_next_r,
    input wire logic          executed_r,
    input wire logic          not_decoded_r,
    input wire rat_instr_type last_instr_r
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    wire tk_ps  = instr_valid && instr_word == RAT_OP_PRESCALER;
    wire tk_sel = instr_valid && instr_word == RAT_OP_PORT_SELECT;
    wire tk_int = instr_valid && instr_word == RAT_OP_INT_CTRL1;
    wire tk_wk  = instr_valid && instr_word == RAT_OP_WAKE_CTRL0;
    wire hit    = tk_ps || tk_sel || tk_int || tk_wk;
    ps_acc_a: assert property (tk_ps |=> acc_load_r && acc_data_r == $past(prescaler_count[3:0]))
        else $error("prescaler low nibble not loaded");
    ps_b_a: assert property (tk_ps |=> b_load_r && b_data_r == $past(prescaler_count[7:4]))
        else $error("prescaler high nibble not loaded");
    sel_acc_a: assert property (tk_sel |=> acc_load_r && !b_load_r && acc_data_r == {1'b0, $past(port_select_register)})
        else $error("port select load wrong");
    int_acc_a: assert property (tk_int |=> acc_load_r && last_instr_r == RAT_INT_CTRL1 && acc_data_r == $past(interrupt_control_one))
        else $error("interrupt control load wrong");
    wake_acc_a: assert property (tk_wk |=> acc_load_r && !b_load_r && acc_data_r == $past(wakeup_control_zero))
        else $error("wakeup control load wrong");
    flags_kept_a: assert property (!carry_write_r && !skip_next_r)
        else $error("carry or skip touched");
    refuse_word_a: assert property (instr_valid && !hit |=> !acc_load_r && !executed_r && not_decoded_r)
        else $error("unknown word acted on");
    idle_cycle_a: assert property (!instr_valid |=> !acc_load_r && !b_load_r && !not_decoded_r)
        else $error("load without instruction");
    cover property (tk_ps ##1 tk_sel);
    cover property (tk_int ##1 tk_wk);
    cover property (instr_valid && !hit);
endmodule : rat_asserts
bind rat_transfer_decoder rat_asserts rat_asserts_inst (.*);
`default_nettype wire

// >>> test/tb_top.sv
// Purpose: random self-checking run of the accumulator-load decoder
// Assumes: inputs driven on the falling edge
// Notes:   expected loads queued by the driver, popped by the monitor
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import rat_pkg::*;
;
    logic          core_clk = 1'b0;
    logic          reset_n = 1'b0;
    logic          instr_valid = 1'b0;
    logic [9:0]    instr_word = 10'h000;
    logic [7:0]    prescaler_count = 8'h00;
    logic [2:0]    port_select_register = 3'h0;
    logic [3:0]    interrupt_control_one = 4'h0, wakeup_control_zero = 4'h0;
    logic [3:0]    acc_data_r, b_data_r;
    logic          acc_load_r, b_load_r, carry_write_r, skip_next_r, executed_r, not_decoded_r;
    rat_instr_type last_instr_r;
    logic [14:0]   exp_q[$];
    logic [14:0]   got;
    logic [9:0]    codes[4] = '{RAT_OP_PRESCALER, RAT_OP_PORT_SELECT, RAT_OP_INT_CTRL1, RAT_OP_WAKE_CTRL0};
    int            failures = 0, compares = 0, op;
    always #50 core_clk = ~core_clk;
    rat_transfer_decoder rat_transfer_decoder_inst (
        .core_clk              (core_clk),
        .reset_n               (reset_n),
        .instr_word            (instr_word),
        .instr_valid           (instr_valid),
        .prescaler_count       (prescaler_count),
        .port_select_register  (port_select_register),
        .interrupt_control_one (interrupt_control_one),
        .wakeup_control_zero   (wakeup_control_zero),
        .acc_data_r            (acc_data_r),
        .acc_load_r            (acc_load_r),
        .b_data_r              (b_data_r),
        .b_load_r              (b_load_r),
        .carry_write_r         (carry_write_r),
        .skip_next_r           (skip_next_r),
        .executed_r            (executed_r),
        .not_decoded_r         (not_decoded_r),
        .last_instr_r          (last_instr_r)
    );
    // pulses first, then kind and data, masked unless a load is shown
    assign got = {executed_r, not_decoded_r, acc_load_r, b_load_r,
                  acc_load_r ? {last_instr_r, b_load_r ? b_data_r : 4'h0, acc_data_r} : 11'h000};
    task automatic chk(input logic [14:0] g, input logic [14:0] e);
        compares++;
        if (g !== e)
        begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic results;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results
    always @(negedge core_clk)
    begin
        if (reset_n)
        begin
            chk(15'(carry_write_r | skip_next_r), 15'h0000);
            if (acc_load_r === 1'b1 || not_decoded_r === 1'b1)
                chk(got, exp_q.size() ? exp_q.pop_front() : 15'h7FFF);
            else
                chk(15'({executed_r, b_load_r}), 15'h0000);
        end
    end
    initial
    begin
        void'($urandom(6));
        repeat (4) @(negedge core_clk);
        reset_n = 1'b1;
        for (int i = 0; i < 400; i++)
        begin
            {prescaler_count, port_select_register} = 11'($urandom);
            {interrupt_control_one, wakeup_control_zero} = 8'($urandom);
            op = $urandom % 6;
            instr_valid = op != 5;
            // op 4 is an unknown word, op 5 a valid code with valid low
            instr_word = op == 4 ? 10'h300 | 10'($urandom % 256) : codes[op % 4];
            case (op)
                0: exp_q.push_back({4'hB, RAT_PRESCALER, prescaler_count});
                1: exp_q.push_back({4'hA, RAT_PORT_SELECT, 4'h0, 1'b0, port_select_register});
                2: exp_q.push_back({4'hA, RAT_INT_CTRL1, 4'h0, interrupt_control_one});
                3: exp_q.push_back({4'hA, RAT_WAKE_CTRL0, 4'h0, wakeup_control_zero});
                4: exp_q.push_back({4'h4, 11'h000});
                default: ;
            endcase
            @(negedge core_clk);
        end
        instr_valid = 1'b0;
        repeat (2) @(negedge core_clk);
        chk(15'(exp_q.size()), 15'h0000);
        results();
    end
endmodule : tb_top
`default_nettype wire
